// ===== verilog/gparam_pkg.sv
// constants shared by the global parameter bank
`default_nettype none
package gparam_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  // parameter numbers of bank 0
  localparam logic [7:0] P_SERIAL_ADDR = 8'h42;
  localparam logic [7:0] P_HEARTBEAT = 8'h44;
  localparam logic [7:0] P_OUT_FUNC = 8'h48;
  localparam logic [7:0] P_REPLY_PAUSE = 8'h4b;
  localparam logic [7:0] P_REPLY_DEST = 8'h4c;
  localparam logic [7:0] P_AUTORUN = 8'h4d;
  localparam logic [7:0] P_ENABLE_FUNC = 8'h50;
  localparam logic [7:0] P_PROTECT = 8'h51;
  localparam logic [7:0] P_COORD_PERSIST = 8'h54;
  localparam logic [7:0] P_RESTORE_INHIBIT = 8'h55;
  localparam logic [7:0] P_SECOND_ADDR = 8'h57;
  localparam logic [7:0] P_STATUS_SELECT = 8'h5c;
  localparam logic [7:0] P_RUN_STATE = 8'h80;
  localparam logic [7:0] P_LOAD_STATE = 8'h81;
  localparam logic [7:0] P_PROG_COUNTER = 8'h82;
  localparam logic [7:0] P_TICK_COUNTER = 8'h84;
  localparam logic [7:0] P_RANDOM = 8'h85;
  localparam logic [7:0] P_SUPPRESS = 8'hff;
  localparam logic [7:0] GLOBAL_BANK = 8'h00;
  // command opcodes
  localparam logic [7:0] OP_READ_AXIS = 8'h06;
  localparam logic [7:0] OP_WRITE_GLOBAL = 8'h09;
  localparam logic [7:0] OP_READ_GLOBAL = 8'h0a;
  localparam logic [7:0] OP_READ_IO = 8'h0f;
  // reply status codes
  localparam logic [7:0] STAT_OK = 8'h64;
  localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
  localparam logic [7:0] STAT_BAD_VALUE = 8'h04;
  // output function field positions and function count
  localparam int OF_ENABLE_LSB = 0;
  localparam int OF_INVERT_LSB = 3;
  localparam int OF_HOME_CLEARS = 7;
  localparam int OUT_FUNCS = 3;
  // setting encodings
  localparam logic [1:0] EN_PLAIN_INPUT = 2'h0;
  localparam logic [1:0] EN_LOW_ACTIVE = 2'h1;
  localparam logic [1:0] EN_HIGH_ACTIVE = 2'h2;
  // reset values, generator taps and value ranges
  localparam logic [7:0] RST_MODULE_ADDR = 8'h01;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [31:0] RST_SEED = 32'h1;
  localparam logic [31:0] LFSR_TAPS = 32'h80200003;
  localparam logic [31:0] RANGE_31BIT = 32'h7fffffff;
  localparam logic [31:0] RANGE_BYTE = 32'h000000ff;
endpackage
`default_nettype wire

// ===== verilog/motion_module_global_params.sv
// global parameter bank: addressing, heartbeat, output mapping, protection, tick, random
// Behaviour
// R01 - answer second address; zero disables it
// R02 - heartbeat expiry stops motor; zero disables
// R03 - bits 0-2 enable alarm, reached, deviation
// R04 - bits 3-5 invert the three functions
// R05 - enabled functions ORed onto one output
// R06 - bit 7: home input clears alarm
// R07 - enable pin: input, low-active, high-active
// R08 - protection level blocks read and/or overwrite
// R09 - leaving read-block erases stored program first; the code raises the erase pulse in the same cycle the new level takes effect
// R10 - coordinate setting 1 writes coordinates to nonvolatile
// R11 - startup restores user variables unless inhibited; the code always restores, since reset clears inhibit_q
// R12 - reply status carries status or type
// R13 - read-only program counter parameter
// R14 - 32-bit millisecond tick, host loadable
// R15 - random read fresh, write loads seed
// R16 - suppression drops direct-mode replies
// R17 - suppression never stored, zero at startup
// R18 - reads of parameters and IO always reply
// R19 - auto-stored parameters written to nonvolatile
// R20 - bad value or read-only write: error
// R21 - valid command restarts heartbeat interval
`timescale 1ns/1ns
`default_nettype none
module motion_module_global_params #(
  parameter int TICK_CYCLES = gparam_pkg::TICK_TIME_NS / gparam_pkg::CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  // decoded command telegram
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input wire logic CMD_DIRECT_I,
  input wire logic [7:0] CMD_TARGET_I,
  input wire logic [7:0] CMD_OPCODE_I,
  input wire logic [7:0] CMD_TYPE_I,
  input wire logic [7:0] CMD_BANK_I,
  input wire logic [31:0] CMD_VALUE_I,
  // reply telegram
  output logic RPL_VALID_O,
  output logic [7:0] RPL_STATUS_O,
  output logic [31:0] RPL_VALUE_O,
  output logic [7:0] RPL_DEST_ADDR_O,
  output logic [7:0] RPL_PAUSE_O,
  // motion status and pins
  input wire logic ALARM_I,
  input wire logic POS_REACHED_I,
  input wire logic POS_ERROR_I,
  input wire logic HOME_PIN_I,
  input wire logic ENABLE_PIN_I,
  output logic GP_OUT_O,
  output logic ALARM_CLEAR_O,
  output logic MOTOR_ENABLE_O,
  output logic ENABLE_PIN_LEVEL_O,
  output logic MOTOR_STOP_O,
  // program store
  input wire logic [1:0] PROG_RUN_STATE_I,
  input wire logic PROG_LOAD_STATE_I,
  input wire logic [31:0] PROG_COUNTER_I,
  output logic PROG_READ_BLOCK_O,
  output logic PROG_WRITE_BLOCK_O,
  output logic PROG_ERASE_O,
  output logic PROG_AUTORUN_O,
  // nonvolatile memory
  output logic COORD_NV_WRITE_O,
  output logic USERVAR_RESTORE_O,
  output logic NV_STORE_O,
  output logic [7:0] NV_STORE_NUM_O,
  output logic [31:0] NV_STORE_VALUE_O
);
  import gparam_pkg::*;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_RESTORE = 3'b010,
    ST_RUN = 3'b100
  } boot_state_e;

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

  boot_state_e st_q;
  logic [7:0] addr_q, second_q, out_func_q, pause_q, dest_q;
  logic [31:0] heartbeat_q, hb_ms_q, tick_q, lfsr_q;
  logic [1:0] en_func_q, protect_q;
  logic autorun_q, coord_q, inhibit_q, status_sel_q, suppress_q;
  logic [TICK_W-1:0] cyc_q;
  logic ms_tick;
  logic cmd_hit, is_write, is_read, write_ok, always_reply;
  logic [31:0] rd_value;
  logic [7:0] status_d;
  logic [2:0] home_s_q, en_s_q;
  logic home_f_q, en_f_q;
  logic [OUT_FUNCS-1:0] func_in, func_act;

  // parameters accepted by a global write; read-only ones are absent
  function automatic logic is_writable(input logic [7:0] num);
    case (num)
      P_SERIAL_ADDR, P_HEARTBEAT, P_OUT_FUNC, P_REPLY_PAUSE, P_REPLY_DEST, P_AUTORUN,
      P_ENABLE_FUNC, P_PROTECT, P_COORD_PERSIST, P_RESTORE_INHIBIT, P_SECOND_ADDR,
      P_STATUS_SELECT, P_TICK_COUNTER, P_RANDOM, P_SUPPRESS: is_writable = 1'b1;
      default: is_writable = 1'b0;
    endcase
  endfunction

  function automatic logic is_known(input logic [7:0] num);
    is_known = is_writable(num) || num == P_RUN_STATE || num == P_LOAD_STATE ||
               num == P_PROG_COUNTER;
  endfunction

  function automatic logic value_ok(input logic [7:0] num, input logic [31:0] v);
    case (num)
      P_SERIAL_ADDR: value_ok = v != RST_WORD && v <= RANGE_BYTE;
      P_HEARTBEAT: value_ok = 1'b1;
      P_ENABLE_FUNC: value_ok = v <= 32'(EN_HIGH_ACTIVE);
      P_PROTECT: value_ok = v <= 32'h3;
      P_AUTORUN, P_COORD_PERSIST, P_RESTORE_INHIBIT, P_STATUS_SELECT, P_SUPPRESS:
        value_ok = v <= 32'h1;
      P_TICK_COUNTER, P_RANDOM: value_ok = v <= RANGE_31BIT;
      default: value_ok = v <= RANGE_BYTE;
    endcase
  endfunction

  // commands are taken only once the startup sequence has finished
  assign CMD_READY_O = st_q == ST_RUN;
  assign cmd_hit = CMD_VALID_I && CMD_READY_O &&
                   (CMD_TARGET_I == addr_q || (second_q != RST_BYTE && CMD_TARGET_I == second_q)); // R01
  assign is_write = cmd_hit && CMD_OPCODE_I == OP_WRITE_GLOBAL && CMD_BANK_I == GLOBAL_BANK;
  assign is_read = cmd_hit && CMD_OPCODE_I == OP_READ_GLOBAL && CMD_BANK_I == GLOBAL_BANK;
  assign write_ok = is_write && is_writable(CMD_TYPE_I) && value_ok(CMD_TYPE_I, CMD_VALUE_I); // R20
  assign always_reply = CMD_OPCODE_I == OP_READ_AXIS || CMD_OPCODE_I == OP_READ_GLOBAL ||
                        CMD_OPCODE_I == OP_READ_IO; // R18

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      st_q <= ST_BOOT;
    end else begin
      unique case (st_q)
        ST_BOOT: st_q <= inhibit_q ? ST_RUN : ST_RESTORE; // R11
        ST_RESTORE: st_q <= ST_RUN;
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_BOOT;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      USERVAR_RESTORE_O <= 1'b0;
    end else begin
      USERVAR_RESTORE_O <= st_q == ST_BOOT && !inhibit_q; // R11
    end
  end

  // plain configuration settings
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      addr_q <= RST_MODULE_ADDR;
      second_q <= RST_BYTE;
      out_func_q <= RST_BYTE;
      pause_q <= RST_BYTE;
      dest_q <= RST_BYTE;
      heartbeat_q <= RST_WORD;
      en_func_q <= EN_PLAIN_INPUT;
      protect_q <= 2'h0;
      autorun_q <= 1'b0;
      coord_q <= 1'b0;
      inhibit_q <= 1'b0;
      status_sel_q <= 1'b0;
      suppress_q <= 1'b0; // R17
    end else if (write_ok) begin
      unique case (CMD_TYPE_I)
        P_SERIAL_ADDR: addr_q <= CMD_VALUE_I[7:0];
        P_SECOND_ADDR: second_q <= CMD_VALUE_I[7:0]; // R01
        P_OUT_FUNC: out_func_q <= CMD_VALUE_I[7:0];
        P_REPLY_PAUSE: pause_q <= CMD_VALUE_I[7:0];
        P_REPLY_DEST: dest_q <= CMD_VALUE_I[7:0];
        P_HEARTBEAT: heartbeat_q <= CMD_VALUE_I;
        P_ENABLE_FUNC: en_func_q <= CMD_VALUE_I[1:0];
        P_PROTECT: protect_q <= CMD_VALUE_I[1:0]; // R08
        P_AUTORUN: autorun_q <= CMD_VALUE_I[0];
        P_COORD_PERSIST: coord_q <= CMD_VALUE_I[0]; // R10
        P_RESTORE_INHIBIT: inhibit_q <= CMD_VALUE_I[0];
        P_STATUS_SELECT: status_sel_q <= CMD_VALUE_I[0];
        P_SUPPRESS: suppress_q <= CMD_VALUE_I[0];
        default: ;
      endcase
    end
  end

  // leaving a read-blocking level pulses the erase in the same cycle as the new level takes effect
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      PROG_ERASE_O <= 1'b0;
    end else begin
      PROG_ERASE_O <= write_ok && CMD_TYPE_I == P_PROTECT && protect_q[0] && !CMD_VALUE_I[0]; // R09
    end
  end

  // tick, heartbeat and random source, no write of tick or seed is dropped
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= ms_tick ? '0 : cyc_q + 1'b1;
    end
  end
  assign ms_tick = cyc_q == TICK_LAST;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      tick_q <= RST_WORD;
    end else if (write_ok && CMD_TYPE_I == P_TICK_COUNTER) begin
      tick_q <= CMD_VALUE_I; // R14
    end else if (ms_tick) begin
      tick_q <= tick_q + 32'h1; // R14
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      hb_ms_q <= RST_WORD;
      MOTOR_STOP_O <= 1'b0;
    end else if (cmd_hit) begin
      hb_ms_q <= RST_WORD; // R21
      MOTOR_STOP_O <= 1'b0;
    end else begin
      if (ms_tick && hb_ms_q != '1) begin
        hb_ms_q <= hb_ms_q + 32'h1;
      end
      if (heartbeat_q != RST_WORD && hb_ms_q >= heartbeat_q) begin
        MOTOR_STOP_O <= 1'b1; // R02
      end
    end
  end

  // a zero seed would lock the generator, so it is forced odd
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      lfsr_q <= RST_SEED;
    end else if (write_ok && CMD_TYPE_I == P_RANDOM) begin
      lfsr_q <= CMD_VALUE_I | RST_SEED; // R15
    end else begin
      lfsr_q <= lfsr_q[0] ? (lfsr_q >> 1) ^ LFSR_TAPS : lfsr_q >> 1; // R15
    end
  end

  // pin inputs: a change counts once the second and third stages agree
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      home_s_q <= 3'h0;
      en_s_q <= 3'h0;
      home_f_q <= 1'b0;
      en_f_q <= 1'b0;
    end else begin
      home_s_q <= {home_s_q[1:0], HOME_PIN_I};
      en_s_q <= {en_s_q[1:0], ENABLE_PIN_I};
      if (home_s_q[1] == home_s_q[2]) begin
        home_f_q <= home_s_q[2];
      end
      if (en_s_q[1] == en_s_q[2]) begin
        en_f_q <= en_s_q[2];
      end
    end
  end

  assign func_in = {POS_ERROR_I, POS_REACHED_I, ALARM_I};
  for (genvar i = 0; i < OUT_FUNCS; i++) begin : g_func
    assign func_act[i] = out_func_q[OF_ENABLE_LSB + i] &&
                         (func_in[i] ^ out_func_q[OF_INVERT_LSB + i]); // R03 R04
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      GP_OUT_O <= 1'b0;
      ALARM_CLEAR_O <= 1'b0;
      MOTOR_ENABLE_O <= 1'b0;
      ENABLE_PIN_LEVEL_O <= 1'b0;
    end else begin
      GP_OUT_O <= |func_act; // R05
      ALARM_CLEAR_O <= out_func_q[OF_HOME_CLEARS] && &home_s_q[2:1] && !home_f_q; // R06
      ENABLE_PIN_LEVEL_O <= en_f_q;
      unique case (en_func_q)
        EN_LOW_ACTIVE: MOTOR_ENABLE_O <= !en_f_q; // R07
        EN_HIGH_ACTIVE: MOTOR_ENABLE_O <= en_f_q; // R07
        default: MOTOR_ENABLE_O <= 1'b1; // R07
      endcase
    end
  end

  assign PROG_READ_BLOCK_O = protect_q[0]; // R08
  assign PROG_WRITE_BLOCK_O = protect_q[1]; // R08
  assign PROG_AUTORUN_O = autorun_q;
  assign COORD_NV_WRITE_O = coord_q; // R10
  assign RPL_DEST_ADDR_O = dest_q;
  assign RPL_PAUSE_O = pause_q;

  always_comb begin
    rd_value = RST_WORD;
    unique case (CMD_TYPE_I)
      P_SERIAL_ADDR: rd_value = {24'h0, addr_q};
      P_SECOND_ADDR: rd_value = {24'h0, second_q};
      P_OUT_FUNC: rd_value = {24'h0, out_func_q};
      P_REPLY_PAUSE: rd_value = {24'h0, pause_q};
      P_REPLY_DEST: rd_value = {24'h0, dest_q};
      P_HEARTBEAT: rd_value = heartbeat_q;
      P_ENABLE_FUNC: rd_value = {30'h0, en_func_q};
      P_PROTECT: rd_value = {30'h0, protect_q};
      P_AUTORUN: rd_value = {31'h0, autorun_q};
      P_COORD_PERSIST: rd_value = {31'h0, coord_q};
      P_RESTORE_INHIBIT: rd_value = {31'h0, inhibit_q};
      P_STATUS_SELECT: rd_value = {31'h0, status_sel_q};
      P_SUPPRESS: rd_value = {31'h0, suppress_q};
      P_RUN_STATE: rd_value = {30'h0, PROG_RUN_STATE_I};
      P_LOAD_STATE: rd_value = {31'h0, PROG_LOAD_STATE_I};
      P_PROG_COUNTER: rd_value = PROG_COUNTER_I; // R13
      P_TICK_COUNTER: rd_value = tick_q;
      P_RANDOM: rd_value = lfsr_q & RANGE_31BIT; // R15
      default: rd_value = RST_WORD;
    endcase
  end

  always_comb begin
    status_d = STAT_OK;
    if ((is_write || is_read) && !is_known(CMD_TYPE_I)) begin
      status_d = STAT_BAD_TYPE;
    end else if (is_write && !write_ok) begin
      status_d = STAT_BAD_VALUE; // R20
    end
  end

  // replies only for direct-mode commands; program-mode commands run silently
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      RPL_VALID_O <= 1'b0;
      RPL_STATUS_O <= RST_BYTE;
      RPL_VALUE_O <= RST_WORD;
    end else begin
      RPL_VALID_O <= cmd_hit && CMD_DIRECT_I && (!suppress_q || always_reply); // R16 R18
      if (cmd_hit) begin
        RPL_STATUS_O <= status_sel_q ? CMD_TYPE_I : status_d; // R12
        RPL_VALUE_O <= is_read && is_known(CMD_TYPE_I) ? rd_value : RST_WORD;
      end
    end
  end

  // auto-stored settings; tick, seed and suppression never go to nonvolatile memory
  always_ff @(posedge CLK_SYS_I) begin
    if (!RESET_N_I) begin
      NV_STORE_O <= 1'b0;
      NV_STORE_NUM_O <= RST_BYTE;
      NV_STORE_VALUE_O <= RST_WORD;
    end else begin
      NV_STORE_O <= write_ok && CMD_TYPE_I != P_TICK_COUNTER && CMD_TYPE_I != P_RANDOM &&
                    CMD_TYPE_I != P_SUPPRESS; // R19 R17
      if (write_ok) begin
        NV_STORE_NUM_O <= CMD_TYPE_I;
        NV_STORE_VALUE_O <= CMD_VALUE_I;
      end
    end
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  chk_second_addr_off: assert property (CMD_VALID_I && CMD_READY_O && CMD_TARGET_I != addr_q && // R01
    second_q == RST_BYTE |=> !RPL_VALID_O && !NV_STORE_O) else $error("second address zero answered");
  chk_heartbeat_stop: assert property (heartbeat_q != RST_WORD && hb_ms_q >= heartbeat_q && // R02
    !cmd_hit |=> MOTOR_STOP_O) else $error("heartbeat expiry did not stop motor");
  chk_heartbeat_off: assert property (heartbeat_q == RST_WORD && !MOTOR_STOP_O |=> // R02
    !MOTOR_STOP_O) else $error("stop raised with heartbeat off");
  chk_out_or_none: assert property (out_func_q[2:0] == 3'h0 |=> !GP_OUT_O) // R05
    else $error("output driven with no function enabled");
  chk_alarm_route: assert property (out_func_q[3:0] == 4'h1 ##0 $stable(out_func_q) && ALARM_I // R03
    |=> GP_OUT_O) else $error("alarm function not routed");
  chk_erase_on_leave: assert property (write_ok && CMD_TYPE_I == P_PROTECT && // R09
    protect_q inside {2'h1, 2'h3} && CMD_VALUE_I[0] == 1'b0 |=> PROG_ERASE_O && !PROG_READ_BLOCK_O)
    else $error("program not erased on protection change");
  // the release edge still shows reset values on the outputs, so it starts no attempt
  chk_enable_plain: assert property (RESET_N_I && en_func_q == EN_PLAIN_INPUT |=> // R07
    MOTOR_ENABLE_O) else $error("plain input mode disabled motor");
  chk_tick_count: assert property (ms_tick && !(write_ok && CMD_TYPE_I == P_TICK_COUNTER) |=> // R14
    tick_q == $past(tick_q) + 32'h1) else $error("tick counter did not advance");
  chk_reads_reply: assert property (cmd_hit && CMD_DIRECT_I && always_reply |=> RPL_VALID_O) // R18
    else $error("read command got no reply");
  chk_suppress_drop: assert property (cmd_hit && suppress_q && CMD_OPCODE_I == OP_WRITE_GLOBAL // R16
    |=> !RPL_VALID_O) else $error("suppressed reply was sent");
  chk_bad_value: assert property (is_write && !write_ok && !status_sel_q |=> // R20
    RPL_STATUS_O != STAT_OK && !NV_STORE_O) else $error("bad write not refused");
  chk_boot_restore: assert property (RESET_N_I && st_q == ST_BOOT && !inhibit_q |=> // R11
    USERVAR_RESTORE_O ##1 CMD_READY_O) else $error("user variables not restored at startup");

  cov_second_addr: cover property (cmd_hit && CMD_TARGET_I == second_q);
  cov_heartbeat: cover property ($rose(MOTOR_STOP_O));
  cov_erase: cover property (PROG_ERASE_O);
  cov_suppressed_read: cover property (cmd_hit && suppress_q && is_read ##1 RPL_VALID_O);
endmodule
`default_nettype wire

// ===== sim/cmd_host.sv
// host model that issues decoded command telegrams and captures replies
`timescale 1ns/1ns
`default_nettype none
module cmd_host (
  // clock and handshake
  input wire logic clk_i,
  input wire logic rdy_i,
  // reply
  input wire logic rv_i,
  input wire logic [7:0] rs_i,
  input wire logic [31:0] rval_i,
  // command
  output logic v_o,
  output logic d_o,
  output logic [7:0] t_o,
  output logic [7:0] op_o,
  output logic [7:0] ty_o,
  output logic [7:0] b_o,
  output logic [31:0] val_o
);
  logic got;
  logic [7:0] st;
  logic [31:0] rd;
  initial begin
    v_o = 1'b0;
    {d_o, t_o, op_o, ty_o, b_o, val_o} = '0;
  end
  // fields are inverted once released so a stale command never looks plausible
  task send(input logic dir, input logic [7:0] tg, op, ty, input logic [31:0] val);
    @(posedge clk_i);
    while (rdy_i !== 1'b1) @(posedge clk_i);
    v_o <= 1'b1;
    {d_o, t_o, op_o, ty_o, b_o, val_o} <= {dir, tg, op, ty, 8'h00, val};
    @(posedge clk_i);
    v_o <= 1'b0;
    {d_o, t_o, op_o, ty_o, b_o, val_o} <= ~{dir, tg, op, ty, 8'h00, val};
    @(negedge clk_i);
    got = rv_i;
    st = rs_i;
    rd = rval_i;
  endtask
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the global parameter bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gparam_pkg::*;
  localparam int TC = 10;
  logic clk, rst_n, cv, cd, alm, rch, perr, home, enp, load, rv, rdy, gp, aclr, men, enl;
  logic stop, rblk, wblk, ers, coord, urst, nvs, arun;
  logic [7:0] ct, co, cty, cb, rs, nvn, dst, pau;
  logic [31:0] cval, pc, rval, v1, v2, v3, nvv;
  logic [1:0] run, prv;
  int failures = 0, n_compared = 0, n_clr = 0, n_ers = 0, n_rst = 0, c;
  logic [7:0] regs [13] = '{8'h42, 8'h44, 8'h48, 8'h4b, 8'h4c, 8'h4d, 8'h50, 8'h51, 8'h54,
    8'h55, 8'h57, 8'h5c, 8'hff};
  logic [7:0] bad_n [6] = '{8'h42, 8'h42, 8'h50, 8'h51, 8'h82, 8'h43};
  logic [31:0] bad_v [6] = '{32'h0, 32'h100, 32'h3, 32'h4, 32'h5, 32'h0};
  logic [7:0] om [8] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h38, 8'h3f, 8'h09, 8'h00};
  logic [1:0] pl [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};

  motion_module_global_params #(.TICK_CYCLES(TC)) motion_module_global_params_i (
    .CLK_SYS_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(cv), .CMD_READY_O(rdy),
    .CMD_DIRECT_I(cd), .CMD_TARGET_I(ct), .CMD_OPCODE_I(co), .CMD_TYPE_I(cty),
    .CMD_BANK_I(cb), .CMD_VALUE_I(cval), .RPL_VALID_O(rv), .RPL_STATUS_O(rs),
    .RPL_VALUE_O(rval), .RPL_DEST_ADDR_O(dst), .RPL_PAUSE_O(pau), .ALARM_I(alm),
    .POS_REACHED_I(rch), .POS_ERROR_I(perr), .HOME_PIN_I(home), .ENABLE_PIN_I(enp),
    .GP_OUT_O(gp), .ALARM_CLEAR_O(aclr), .MOTOR_ENABLE_O(men), .ENABLE_PIN_LEVEL_O(enl),
    .MOTOR_STOP_O(stop), .PROG_RUN_STATE_I(run), .PROG_LOAD_STATE_I(load),
    .PROG_COUNTER_I(pc), .PROG_READ_BLOCK_O(rblk), .PROG_WRITE_BLOCK_O(wblk),
    .PROG_ERASE_O(ers), .PROG_AUTORUN_O(arun), .COORD_NV_WRITE_O(coord),
    .USERVAR_RESTORE_O(urst), .NV_STORE_O(nvs), .NV_STORE_NUM_O(nvn), .NV_STORE_VALUE_O(nvv));

  cmd_host cmd_host_i (.clk_i(clk), .rdy_i(rdy), .rv_i(rv), .rs_i(rs), .rval_i(rval),
    .v_o(cv), .d_o(cd), .t_o(ct), .op_o(co), .ty_o(cty), .b_o(cb), .val_o(cval));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pulse outputs are counted here so a test can check how many fired
  always @(posedge clk) begin
    n_clr <= n_clr + int'(aclr === 1'b1);
    n_ers <= n_ers + int'(ers === 1'b1);
    n_rst <= n_rst + int'(urst === 1'b1);
  end

  task chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task wr(input logic [7:0] n, input logic [31:0] v);
    cmd_host_i.send(1'b1, 8'h01, OP_WRITE_GLOBAL, n, v);
  endtask

  task rd(input logic [7:0] n);
    cmd_host_i.send(1'b1, 8'h01, OP_READ_GLOBAL, n, 32'h0);
  endtask

  task do_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(4);
  endtask

  function automatic logic [31:0] gpx(input logic [7:0] m, input logic [2:0] s);
    return {31'h0, |(m[2:0] & (s ^ m[5:3]))};
  endfunction

  initial begin
    #500000;
    failures++;
    end_sim;
  end

  initial begin
    {rst_n, alm, rch, perr, home, enp, load} = '0;
    run = 2'h2;
    pc = 32'h0000abcd;
    do_rst;
    @(posedge clk);
    load <= 1'b1;
    chk("restore", n_rst, 1);
    foreach (regs[i]) begin
      rd(regs[i]);
      chk("reset_val", cmd_host_i.rd, (regs[i] == P_SERIAL_ADDR) ? 32'h1 : 32'h0);
    end
    rd(P_RUN_STATE);
    chk("run_state", cmd_host_i.rd, 32'h2);
    rd(P_LOAD_STATE);
    chk("load_state", cmd_host_i.rd, 32'h1);
    foreach (bad_n[i]) begin
      wr(bad_n[i], bad_v[i]);
      chk("bad_status", 32'(cmd_host_i.st != STAT_OK), 32'h1);
    end
    rd(P_PROG_COUNTER);
    chk("pc_kept", cmd_host_i.rd, pc);
    rd(P_SERIAL_ADDR);
    chk("addr_kept", cmd_host_i.rd, 32'h1);
    $display("done access");
    wr(P_SECOND_ADDR, 32'h22);
    chk("nv_store", nvs, 1'b1);
    chk("nv_num", nvn, P_SECOND_ADDR);
    chk("nv_val", nvv, 32'h22);
    cmd_host_i.send(1'b1, 8'h22, OP_READ_GLOBAL, P_SECOND_ADDR, 32'h0);
    chk("second_rpl", cmd_host_i.got, 1'b1);
    chk("second_val", cmd_host_i.rd, 32'h22);
    wr(P_SECOND_ADDR, 32'h0);
    cmd_host_i.send(1'b1, 8'h22, OP_READ_GLOBAL, P_SECOND_ADDR, 32'h0);
    chk("second_off", cmd_host_i.got, 1'b0);
    wr(P_STATUS_SELECT, 32'h1);
    rd(P_SECOND_ADDR);
    chk("status_type", cmd_host_i.st, P_SECOND_ADDR);
    wr(P_STATUS_SELECT, 32'h0);
    rd(P_SECOND_ADDR);
    chk("status_ok", cmd_host_i.st, STAT_OK);
    wr(P_COORD_PERSIST, 32'h1);
    chk("coord_on", coord, 1'b1);
    wr(P_COORD_PERSIST, 32'h0);
    chk("coord_off", coord, 1'b0);
    wr(P_AUTORUN, 32'h1);
    wr(P_REPLY_PAUSE, 32'h0f);
    wr(P_REPLY_DEST, 32'h05);
    chk("nv_dest", nvn, P_REPLY_DEST);
    chk("autorun", arun, 1'b1);
    chk("pause", pau, 8'h0f);
    chk("dest", dst, 8'h05);
    $display("done address");
    foreach (om[i]) begin
      wr(P_OUT_FUNC, {24'h0, om[i]});
      for (int s = 0; s < 8; s++) begin
        @(posedge clk);
        {perr, rch, alm} <= s[2:0];
        cyc(3);
        chk("gp_out", gp, gpx(om[i], s[2:0]));
      end
    end
    for (int b = 1; b >= 0; b--) begin
      wr(P_OUT_FUNC, {24'h0, b[0], 7'h0});
      c = n_clr;
      @(posedge clk);
      home <= 1'b1;
      cyc(8);
      chk("alarm_clr", n_clr - c, b);
      @(posedge clk);
      home <= 1'b0;
      cyc(8);
    end
    for (int m = 0; m < 3; m++) begin
      wr(P_ENABLE_FUNC, m);
      for (int p = 0; p < 2; p++) begin
        @(posedge clk);
        enp <= p[0];
        cyc(6);
        chk("motor_en", men, (m == 0) ? 1 : ((m == 1) ? !p[0] : p[0]));
        chk("pin_lvl", enl, p[0]);
      end
    end
    $display("done pins");
    prv = 2'h0;
    foreach (pl[i]) begin
      c = n_ers;
      wr(P_PROTECT, pl[i]);
      cyc(2);
      chk("erase", n_ers - c, prv[0] & !pl[i][0]);
      chk("blocks", {wblk, rblk}, pl[i]);
      prv = pl[i];
    end
    wr(P_HEARTBEAT, 32'h3);
    cyc(20);
    chk("hb_early", stop, 1'b0);
    cyc(25);
    chk("hb_stop", stop, 1'b1);
    rd(P_HEARTBEAT);
    cyc(1);
    chk("hb_clear", stop, 1'b0);
    cyc(20);
    chk("hb_restart", stop, 1'b0);
    wr(P_HEARTBEAT, 32'h0);
    cyc(60);
    chk("hb_off", stop, 1'b0);
    wr(P_TICK_COUNTER, 32'h1000);
    cyc(TC * 4 + 5);
    rd(P_TICK_COUNTER);
    chk("tick", 32'((cmd_host_i.rd - 32'h1000) inside {32'h4, 32'h5}), 32'h1);
    wr(P_RANDOM, 32'h1234);
    rd(P_RANDOM);
    v1 = cmd_host_i.rd;
    wr(P_RANDOM, 32'h1234);
    rd(P_RANDOM);
    v2 = cmd_host_i.rd;
    rd(P_RANDOM);
    v3 = cmd_host_i.rd;
    chk("rnd_seed", v2, v1);
    chk("rnd_fresh", 32'(v3 !== v1), 32'h1);
    chk("rnd_range", v3[31], 1'b0);
    $display("done timers");
    wr(P_SUPPRESS, 32'h1);
    chk("sup_nv", nvs, 1'b0);
    wr(P_COORD_PERSIST, 32'h0);
    chk("sup_write", cmd_host_i.got, 1'b0);
    for (int k = 0; k < 3; k++) begin
      cmd_host_i.send(1'b1, 8'h01, (k == 0) ? OP_READ_GLOBAL : ((k == 1) ? OP_READ_AXIS :
        OP_READ_IO), P_SUPPRESS, 32'h0);
      chk("sup_read", cmd_host_i.got, 1'b1);
    end
    cmd_host_i.send(1'b0, 8'h01, OP_READ_GLOBAL, P_SUPPRESS, 32'h0);
    chk("prog_mode", cmd_host_i.got, 1'b0);
    do_rst;
    rd(P_SUPPRESS);
    chk("sup_reset", cmd_host_i.rd, 32'h0);
    chk("restore2", n_rst, 2);
    $display("done suppress");
    end_sim;
  end
endmodule
`default_nettype wire
